// ### aci_map.svh
`ifndef ACI_MAP_SVH
`define ACI_MAP_SVH
// Bus address, upper six bits
`define ACI_ADDR_HI 6'b011010
`define ACI_SMB_COUNT 8'h07
`define ACI_STACK_DEPTH 7
`define ACI_HIST_DEPTH 6
`define ACI_BLOCK_MAX 32
// Subaddresses that steer the wait logic and the block-format decode
`define ACI_SUB_MCR 7'h01
`define ACI_SUB_VOL 7'h04
`define ACI_SUB_BASS 7'h06
`define ACI_SUB_TREBLE 7'h07
`define ACI_SUB_EQ_LO 7'h0A
`define ACI_SUB_EQ_HI 7'h17
// Clock rate and wait times in microseconds (32, 44.1, 48 kHz)
`define ACI_CLK_MHZ 250
`define ACI_VOL_32_US 62000
`define ACI_VOL_44_US 49000
`define ACI_VOL_48_US 41000
`define ACI_TONE_32_US 231000
`define ACI_TONE_44_US 167000
`define ACI_TONE_48_US 153000
`define ACI_EQ_32_US 15000
`define ACI_EQ_44_US 190
`define ACI_EQ_48_US 300
`define ACI_SHORT_US 150
`define ACI_SHORT_32_US 15000
`define ACI_SERIES_LEN 8
`endif

// ### aci_pkg.sv
package aci_pkg;
	typedef enum logic [1:0] {ACI_FS_32, ACI_FS_44, ACI_FS_48} aci_rate_t;
	typedef enum {S_IDLE, S_ADDR, S_ACK, S_WR, S_HOLD, S_RD, S_RACK, S_RLOAD} aci_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} aci_line_t;
endpackage

// ### aci_i2c_slave.sv
`include "aci_map.svh"
`timescale 1ns/10ps
`default_nettype none
module aci_i2c_slave import aci_pkg::*; #(
	parameter int unsigned VOL_CYC [3] = '{`ACI_VOL_32_US * `ACI_CLK_MHZ,
		`ACI_VOL_44_US * `ACI_CLK_MHZ, `ACI_VOL_48_US * `ACI_CLK_MHZ},
	parameter int unsigned TONE_CYC [3] = '{`ACI_TONE_32_US * `ACI_CLK_MHZ,
		`ACI_TONE_44_US * `ACI_CLK_MHZ, `ACI_TONE_48_US * `ACI_CLK_MHZ},
	parameter int unsigned EQ_CYC [3] = '{`ACI_EQ_32_US * `ACI_CLK_MHZ,
		`ACI_EQ_44_US * `ACI_CLK_MHZ, `ACI_EQ_48_US * `ACI_CLK_MHZ},
	parameter int unsigned SHORT_CYC = `ACI_SHORT_US * `ACI_CLK_MHZ,
	parameter int unsigned SHORT32_CYC = `ACI_SHORT_32_US * `ACI_CLK_MHZ,
	parameter int unsigned SERIES_LEN = `ACI_SERIES_LEN
)(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Two-wire bus, open drain
	input wire aci_line_t bus_in,
	output aci_line_t bus_out,
	output aci_line_t bus_oe_out,
	// Configuration
	input wire logic address_select_pin_in,
	input wire aci_rate_t rate_in,
	// Status
	output logic busy_out
);
	generate
		if (SERIES_LEN < 1 || SERIES_LEN > 255) begin : g_bad
			$error("SERIES_LEN out of range");
		end
	endgenerate

	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, sel_m, sel_s;
	aci_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shreg, tx, cmd, last_sub;
	logic [7:0] stack [`ACI_STACK_DEPTH];
	logic [7:0] hist [`ACI_HIST_DEPTH];
	logic [5:0] byte_idx;
	logic [2:0] rd_idx;
	logic [7:0] series;
	logic [31:0] busy;
	logic is_read, smb, wr_frame, got_data, block, hold_req, sda_oe, scl_oe;

	// Pins pass two flops before use
	always_ff @(posedge clk_in) begin
		scl_m <= bus_in.scl;
		scl_s <= scl_m;
		scl_p <= scl_s;
		sda_m <= bus_in.sda;
		sda_s <= sda_m;
		sda_p <= sda_s;
		sel_m <= address_select_pin_in;
		sel_s <= sel_m;
	end

	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start_det = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
	wire [7:0] byte_in = {shreg[6:0], sda_s};
	wire got_byte = scl_rise && bit_cnt == 3'd7 && (state == S_ADDR || state == S_WR);
	wire addr_hit = byte_in[7:2] == `ACI_ADDR_HI && byte_in[1] == sel_s;
	wire wr_byte = got_byte && state == S_WR;
	wire [6:0] byte_sub = byte_in[6:0];
	wire byte_fmt = byte_sub == `ACI_SUB_MCR || byte_sub == `ACI_SUB_BASS || byte_sub == `ACI_SUB_TREBLE;
	wire is_cmd = wr_byte && byte_idx == 6'd0;
	wire is_count = wr_byte && byte_idx == 6'd1 && block;
	wire is_data = wr_byte && !is_cmd && !is_count;
	// Block data starts one byte later than write-byte data
	wire first_data = is_data && byte_idx == (block ? 6'd2 : 6'd1);
	wire ack_end = state == S_ACK && scl_fall && sda_oe;
	wire commit = (start_det || stop_det) && wr_frame && got_data;

	// Readback source: plain pops the store, read after a write frame is framed
	wire [7:0] rd_plain = rd_idx == 3'd7 ? 8'hFF : stack[3'd6 - rd_idx];
	wire [7:0] rd_smb = rd_idx == 3'd0 ? `ACI_SMB_COUNT :
		rd_idx == 3'd1 ? last_sub : hist[3'd7 - rd_idx];
	wire [7:0] rd_sel = smb ? rd_smb : rd_plain;

	// Wait length of the command that just completed
	wire [1:0] ri = rate_in == 2'd3 ? 2'd2 : rate_in;
	wire [6:0] csub = cmd[6:0];
	wire is_vol = csub == `ACI_SUB_VOL;
	wire is_tone = csub == `ACI_SUB_BASS || csub == `ACI_SUB_TREBLE;
	wire is_eq = csub >= `ACI_SUB_EQ_LO && csub <= `ACI_SUB_EQ_HI;
	wire series_end = series == 8'(SERIES_LEN - 1);
	wire [31:0] short_wait = ri == 2'd0 ? SHORT32_CYC : SHORT_CYC;
	// Tone uses the full step; a finer scaling would need the old setting
	wire [31:0] wait_len = is_vol ? VOL_CYC[ri] :
		is_tone ? TONE_CYC[ri] :
		is_eq ? EQ_CYC[ri] :
		series_end ? short_wait : 32'h0;

	// Serial engine
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= S_IDLE;
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			is_read <= 1'b0;
			smb <= 1'b0;
			wr_frame <= 1'b0;
			rd_idx <= 3'h0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (start_det) begin
			state <= S_ADDR;
			bit_cnt <= 3'h0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (stop_det) begin
			state <= S_IDLE;
			wr_frame <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			case (state)
				S_ADDR, S_WR: begin
					if (scl_rise) begin
						shreg <= byte_in;
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7) begin
							if (state == S_ADDR && !addr_hit) begin
								state <= S_IDLE;
							end else begin
								state <= S_ACK;
							end
							if (state == S_ADDR && addr_hit) begin
								is_read <= byte_in[0];
								smb <= byte_in[0] & wr_frame;
								wr_frame <= wr_frame | ~byte_in[0];
								rd_idx <= 3'h0;
							end
						end
					end
				end
				S_ACK: begin
					if (scl_fall && !sda_oe) begin
						sda_oe <= 1'b1;
					end else if (ack_end) begin
						if (is_read) begin
							tx <= rd_sel;
							sda_oe <= ~rd_sel[7];
							state <= S_RD;
						end else if (hold_req && busy != 32'h0) begin
							sda_oe <= 1'b0;
							scl_oe <= 1'b1;
							state <= S_HOLD;
						end else begin
							sda_oe <= 1'b0;
							state <= S_WR;
						end
					end
				end
				S_HOLD: begin
					if (busy == 32'h0) begin
						scl_oe <= 1'b0;
						state <= S_WR;
					end
				end
				S_RD: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7) begin
							sda_oe <= 1'b0;
							state <= S_RACK;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						if (!sda_s) begin
							rd_idx <= rd_idx + 3'd1;
							state <= S_RLOAD;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_RLOAD: begin
					if (scl_fall) begin
						tx <= rd_sel;
						sda_oe <= ~rd_sel[7];
						state <= S_RD;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Written bytes, store and command decode
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			byte_idx <= 6'h0;
			cmd <= 8'h00;
			last_sub <= 8'h00;
			block <= 1'b0;
			got_data <= 1'b0;
			hold_req <= 1'b0;
			for (int i = 0; i < `ACI_STACK_DEPTH; i++) begin
				stack[i] <= 8'h00;
			end
			for (int i = 0; i < `ACI_HIST_DEPTH; i++) begin
				hist[i] <= 8'h00;
			end
		end else begin
			if (start_det) begin
				byte_idx <= 6'h0;
			end else if (wr_byte && byte_idx != 6'h3F) begin
				byte_idx <= byte_idx + 6'd1;
			end
			if (commit) begin
				got_data <= 1'b0;
			end else if (is_data) begin
				got_data <= 1'b1;
			end
			if (ack_end || start_det) begin
				hold_req <= 1'b0;
			end else if (first_data) begin
				hold_req <= 1'b1;
			end
			if (is_cmd) begin
				cmd <= byte_in;
				block <= byte_in[7] & ~byte_fmt;
			end
			if (wr_byte && !is_count) begin
				stack[0] <= byte_in;
				for (int i = 1; i < `ACI_STACK_DEPTH; i++) begin
					stack[i] <= stack[i - 1];
				end
			end
			if (is_data) begin
				last_sub <= cmd;
				hist[0] <= byte_in;
				for (int i = 1; i < `ACI_HIST_DEPTH; i++) begin
					hist[i] <= hist[i - 1];
				end
			end
		end
	end

	// Busy timer; the wait is served on the next command's first data byte
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			busy <= 32'h0;
			series <= 8'h00;
		end else if (commit) begin
			busy <= wait_len;
			series <= series_end ? 8'h00 : series + 8'd1;
		end else if (busy != 32'h0) begin
			busy <= busy - 32'd1;
		end
	end

	assign bus_out = '0;
	assign bus_oe_out = '{scl: scl_oe, sda: sda_oe};
	assign busy_out = busy != 32'h0;

	a_start_seen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		start_det |=> state == S_ADDR && bit_cnt == 3'h0)
		else $error("start not taken");
	a_stop_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		stop_det && !start_det |=> state == S_IDLE && !bus_oe_out.sda && !bus_oe_out.scl)
		else $error("stop did not release bus");
	a_addr_reject: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		got_byte && state == S_ADDR && !addr_hit && !start_det && !stop_det |=> state == S_IDLE)
		else $error("foreign address accepted");
	a_stack_push: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_byte && !is_count && !start_det && !stop_det |=> stack[0] == $past(byte_in) && stack[1] == $past(stack[0]))
		else $error("store not updated");
	a_count_skip: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		is_count |=> stack[0] == $past(stack[0]))
		else $error("count byte stored");
	a_first_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ack_end && is_read && !smb && rd_idx == 3'h0 && !start_det && !stop_det
		|=> tx == $past(stack[6]) && state == S_RD)
		else $error("first read not oldest");
	a_smb_count: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ack_end && is_read && smb && rd_idx == 3'h0 && !start_det && !stop_det |=> tx == 8'h07)
		else $error("count byte wrong");
	a_pop_next: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state == S_RACK && scl_rise && !sda_s && !start_det && !stop_det
		|=> rd_idx == $past(rd_idx) + 3'd1 ##0 state == S_RLOAD)
		else $error("ack did not pop");
	a_hold_clock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state == S_HOLD && busy > 32'd2 && !start_det && !stop_det |=> bus_oe_out.scl ##1 bus_oe_out.scl)
		else $error("clock not held");
	a_vol_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		commit && is_vol |=> busy == VOL_CYC[$past(ri)])
		else $error("volume wait wrong");
endmodule
`default_nettype wire

// ### aci_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aci_host_model (
	// Resolved bus wires and bench clock
	input wire logic clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	// Pull-downs, high while pulling low
	output logic scl_low_out,
	output logic sda_low_out
);
	logic stretched = 1'b0;
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	task automatic q;
		#31.25;
	endtask
	// No bit goes on while the device holds the clock low, for up to 40000 clocks; no fixed gap needed
	task automatic scl_up;
		int n;
		n = 0;
		scl_low_out = 1'b0;
		#1;
		if (scl_in !== 1'b1) stretched = 1'b1;
		while (scl_in !== 1'b1 && n < 40000) begin
			@(posedge clk_in);
			n++;
		end
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low_out = ~b;
		q;
		scl_up;
		q;
		r = sda_in;
		q;
		scl_low_out = 1'b1;
		q;
	endtask
	// One shape of start and stop for reads and writes
	task automatic start;
		sda_low_out = 1'b0;
		q;
		scl_up;
		q;
		sda_low_out = 1'b1;
		q;
		scl_low_out = 1'b1;
		q;
	endtask
	task automatic stop;
		sda_low_out = 1'b1;
		q;
		scl_up;
		q;
		sda_low_out = 1'b0;
		q;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Caller acks all but the last byte, then stops
	task automatic rd_byte(input logic host_read_acknowledge, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(~host_read_acknowledge, r);
	endtask
endmodule
`default_nettype wire

// ### test_audio_ctrl_i2c_smbus_slave.sv
`timescale 1ns/10ps
`default_nettype none
module test_audio_ctrl_i2c_smbus_slave import aci_pkg::*; ;
	localparam int LIMIT = 95000;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic pin = 1'b0;
	aci_rate_t rate = ACI_FS_48;
	aci_line_t d_out, d_oe, line_w;
	logic busy, busy_q = 1'b0, h_scl_low, h_sda_low;
	wire scl_w, sda_w;
	int error_cnt = 0, check_count = 0, cyc_cnt = 0, fall_cyc = 0;
	always #2 clk_in = ~clk_in;
	// Pull-ups: a released wire reads high
	assign scl_w = ~(h_scl_low | d_oe.scl);
	assign sda_w = ~(h_sda_low | d_oe.sda);
	assign line_w = {scl_w, sda_w};
	// Short waits keep the run small; expectations use these figures
	aci_i2c_slave #(.VOL_CYC('{6000, 4500, 3000}), .TONE_CYC('{12000, 10000, 8000}), .EQ_CYC('{1500, 300, 200}),
		.SHORT_CYC(60), .SHORT32_CYC(120), .SERIES_LEN(8)) i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.bus_in(line_w), .bus_out(d_out), .bus_oe_out(d_oe), .address_select_pin_in(pin), .rate_in(rate),
		.busy_out(busy));
	aci_host_model i_host (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w), .scl_low_out(h_scl_low),
		.sda_low_out(h_sda_low));
	task automatic end_of_test;
		if (error_cnt == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int v, input int lo, input int hi);
		check_count++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("mismatch at %0t: %0d cycles, expected %0d to %0d", $time, v, lo, hi);
		end
	endtask
	task automatic wr_seq(input logic [7:0] b [$]);
		logic a;
		foreach (b[i]) begin
			i_host.wr_byte(b[i], a);
			chk8({7'h00, a}, 8'h01);
		end
	endtask
	task automatic rd_seq(input logic [7:0] exp [$]);
		logic [7:0] d;
		foreach (exp[i]) begin
			i_host.rd_byte(i < exp.size() - 1, d);
			chk8(d, exp[i]);
		end
	endtask
	task automatic rd_frame(input logic [7:0] exp [$]);
		i_host.start;
		wr_seq('{8'h69});
		rd_seq(exp);
		i_host.stop;
	endtask
	task automatic t_stack;
		i_host.start;
		wr_seq('{8'h68, 8'h05, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16});
		i_host.stop;
		rd_frame('{8'h05, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16});
		repeat (4) @(posedge clk_in);
		chk8({4'h0, d_out, d_oe}, 8'h00);
	endtask
	task automatic t_smbus;
		logic a;
		@(posedge clk_in);
		#1 pin = 1'b1;
		repeat (4) @(posedge clk_in);
		i_host.start;
		i_host.wr_byte(8'h68, a);
		chk8({7'h00, a}, 8'h00);
		i_host.stop;
		i_host.start;
		wr_seq('{8'h6A, 8'h85, 8'h06, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26});
		i_host.start;
		wr_seq('{8'h6B});
		rd_seq('{8'h07, 8'h85, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26});
		i_host.stop;
		@(posedge clk_in);
		#1 pin = 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	// Timer may run from the stop or only while stretching, so allow one frame's length of slack
	task automatic t_wait(input aci_rate_t r, input logic [7:0] sub, input int nd, input logic [7:0] dat, input int n);
		logic [7:0] b [$];
		int t0;
		b = '{8'h68, sub};
		repeat (nd) b.push_back(dat);
		@(posedge clk_in);
		#1 rate = r;
		i_host.start;
		wr_seq(b);
		t0 = cyc_cnt;
		i_host.stop;
		i_host.start;
		wr_seq('{8'h68, 8'h05, 8'h00});
		i_host.stretched = 1'b0;
		wr_seq('{8'h00});
		chk8({7'h00, i_host.stretched}, 8'h01);
		i_host.stop;
		chk_rng(fall_cyc - t0, n - 2, n + 1000);
	endtask
	always @(posedge clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		busy_q <= busy;
		if (busy_q === 1'b1 && busy === 1'b0) fall_cyc <= cyc_cnt;
		if (cyc_cnt == LIMIT) begin
			error_cnt++;
			end_of_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		repeat (4) @(posedge clk_in);
		t_stack;
		t_smbus;
		t_wait(ACI_FS_32, 8'h04, 6, 8'h00, 6000);
		t_wait(ACI_FS_44, 8'h04, 6, 8'h00, 4500);
		t_wait(ACI_FS_48, 8'h04, 6, 8'h00, 3000);
		t_wait(ACI_FS_48, 8'h86, 1, 8'h1C, 8000);
		rd_frame('{8'h00, 8'h00, 8'h86, 8'h1C, 8'h05, 8'h00, 8'h00});
		t_wait(ACI_FS_32, 8'h0A, 5, 8'h00, 1500);
		end_of_test;
	end
endmodule
`default_nettype wire
